// ==== logic/kwu_pkg.sv ====
// Purpose: Constants and types for the key wakeup block
// Assumes: 32-bit classic Wishbone, byte address = 4 * index
// Notes:   Control bytes sit in the low data bits
package kwu_pkg;
    localparam int unsigned KEY_PINS = 8;
    localparam int unsigned BYTE_W   = 8;
    localparam int unsigned DATA_W   = 32;
    localparam int unsigned ADDR_W   = 14;
    localparam int unsigned IDX_W    = 12;
    localparam int unsigned IDX_LSB  = 2;
    // Register indices
    localparam logic [IDX_W-1:0] CTRL_LOW_IDX  = 12'hFC4;
    localparam logic [IDX_W-1:0] CTRL_HIGH_IDX = 12'hFC5;
    localparam logic [IDX_W-1:0] STOP_CTRL_IDX = 12'hFC6;
    localparam logic [IDX_W-1:0] STATUS_IDX    = 12'hFC7;
    // Reset values
    localparam logic [BYTE_W-1:0] CTRL_RESET = 8'h00;
    // Field layout of a pin pair
    localparam int unsigned PAIR_W    = 2;
    localparam int unsigned ENABLE_OF = 0;
    localparam int unsigned LEVEL_OF  = 1;
    // Stop control fields
    localparam int unsigned STOP_CMD_BIT   = 0;
    localparam int unsigned LEVEL_MODE_BIT = 1;
    // Status fields
    localparam int unsigned ST_ACTIVE_BIT  = 0;
    localparam int unsigned ST_HIT_BIT     = 1;
    localparam int unsigned ST_SKIP_BIT    = 2;
    localparam int unsigned ST_REL_BIT     = 3;
    localparam int unsigned ST_KEYS_LSB    = 8;
    typedef logic [BYTE_W-1:0] ctrl_byte_t;
    typedef enum logic {ST_RUN, ST_STOP} stop_state_t;
endpackage

// ==== logic/wake_if.sv ====
// Purpose: Carrier between the wakeup control, detector and sequencer
// Assumes: One clock
// Notes:   Detector side is purely combinational
`timescale 1ns/100ps
`default_nettype none
interface wake_if;
    logic [kwu_pkg::KEY_PINS-1:0] keyIn;
    logic [kwu_pkg::KEY_PINS-1:0] keyEnable;
    logic [kwu_pkg::KEY_PINS-1:0] keyLevel;
    logic                         stopPin;
    logic [kwu_pkg::KEY_PINS-1:0] keyHit;
    logic                         levelHit;
    logic                         levelMode;
    logic                         stopCmd;
    logic                         stopActive;
    logic                         skipPulse;
    logic                         relPulse;
    modport detect (input keyIn, keyEnable, keyLevel, stopPin,
                    output keyHit, levelHit);
    modport seq    (input levelHit, keyHit, stopPin, levelMode, stopCmd,
                    output stopActive, skipPulse, relPulse);
    modport ctrl   (output keyIn, keyEnable, keyLevel, stopPin,
                    levelMode, stopCmd,
                    input keyHit, levelHit, stopActive, skipPulse, relPulse);
endinterface
`default_nettype wire

// ==== logic/release_detect.sv ====
// Purpose: Level release detection, no clock needed
// Assumes: Pin inputs settle without a clock
// Notes:   Works while the system clock is halted
`timescale 1ns/100ps
`default_nettype none
module release_detect (
    // Link to control
    wake_if.detect w
);
    ////////////////////////////////////////////////////////////////////
    genvar k;
    generate
        for (k = 0; k < kwu_pkg::KEY_PINS; k++) begin : g_pin
            // Enabled pin at its programmed level
            assign w.keyHit[k] = w.keyEnable[k] & ~(w.keyIn[k] ^ w.keyLevel[k]);
        end
    endgenerate
    // Stop pin has no disable
    assign w.levelHit = w.stopPin | (|w.keyHit);
endmodule // release_detect
`default_nettype wire

// ==== logic/stop_sequencer.sv ====
// Purpose: Tracks STOP entry, skip and release
// Assumes: Stop command is a one-cycle pulse
// Notes:   Edge mode releases on a stop pin rise with no key hit
`timescale 1ns/100ps
`default_nettype none
module stop_sequencer (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic rst_n,
    // Link to control
    wake_if.seq       w
);
    ////////////////////////////////////////////////////////////////////
    kwu_pkg::stop_state_t state_ff;
    kwu_pkg::stop_state_t nxt_state;
    logic                 stopPrev_ff;
    logic                 nxt_stopPrev;
    logic                 stopRise;
    logic                 skip;
    logic                 rel;
    logic                 stopActive_ff;
    logic                 nxt_stopActive;

    assign stopRise = w.stopPin & ~stopPrev_ff & ~(|w.keyHit);

    always_comb begin
        nxt_state    = state_ff;
        nxt_stopPrev = w.stopPin;
        skip         = 1'b0;
        rel          = 1'b0;
        unique case (state_ff)
            kwu_pkg::ST_RUN: begin
                if (w.stopCmd) begin
                    if (w.levelMode && w.levelHit) begin
                        skip = 1'b1;
                    end else begin
                        nxt_state = kwu_pkg::ST_STOP;
                    end
                end
            end
            kwu_pkg::ST_STOP: begin
                if (w.levelMode ? w.levelHit : stopRise) begin
                    rel       = 1'b1;
                    nxt_state = kwu_pkg::ST_RUN;
                end
            end
        endcase
        nxt_stopActive = (nxt_state == kwu_pkg::ST_STOP);
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff      <= kwu_pkg::ST_RUN;
            stopPrev_ff   <= 1'b0;
            stopActive_ff <= 1'b0;
        end else begin
            state_ff      <= nxt_state;
            stopPrev_ff   <= nxt_stopPrev;
            stopActive_ff <= nxt_stopActive;
        end
    end

    // Registered so the mode output comes from a flip-flop
    assign w.stopActive = stopActive_ff;
    assign w.skipPulse  = skip;
    assign w.relPulse   = rel;

    ////////////////////////////////////////////////////////////////////
    property p_level_release;
        @(posedge sys_clk) disable iff (!rst_n)
        (state_ff == kwu_pkg::ST_STOP) && w.levelMode && w.levelHit
        |=> (state_ff == kwu_pkg::ST_RUN);
    endproperty
    a_level_release: assert property (p_level_release)
        else $error("level release did not end stop");

    property p_hold_stop;
        @(posedge sys_clk) disable iff (!rst_n)
        (state_ff == kwu_pkg::ST_STOP) && w.levelMode && !w.levelHit
        |=> (state_ff == kwu_pkg::ST_STOP);
    endproperty
    a_hold_stop: assert property (p_hold_stop)
        else $error("stop ended with no release source");
endmodule // stop_sequencer
`default_nettype wire

// ==== logic/key_wakeup_stop_release.sv ====
// Purpose: Key wakeup STOP release block with Wishbone registers
// Assumes: Classic Wishbone, pins synchronous to sys_clk
// Notes:   wakeRelease is combinational so it works without clock
//
// Contract
// - After reset only stop pin releases
// - Key pin counts only when enabled
// - Level bit picks low or high release
// - Low register holds pins zero to three
// - High register holds pins four to seven
// - Stop pin is always a release input; in edge mode its rise ends STOP only while no key hit is present
// - Level mode releases on stop or key
// - Release already present skips STOP entry in level mode only
//
// Added by the designer: register access over Wishbone.
`timescale 1ns/100ps
`default_nettype none
module key_wakeup_stop_release (
    // Clock and reset
    input  wire logic                         sys_clk,
    input  wire logic                         rst_n,
    // Wishbone slave
    input  wire logic                         wb_cyc_i,
    input  wire logic                         wb_stb_i,
    input  wire logic                         wb_we_i,
    input  wire logic [kwu_pkg::ADDR_W-1:0]   wb_adr_i,
    input  wire logic [3:0]                   wb_sel_i,
    input  wire logic [kwu_pkg::DATA_W-1:0]   wb_dat_i,
    output      logic [kwu_pkg::DATA_W-1:0]   wb_dat_o,
    output      logic                         wb_ack_o,
    // Wakeup pins
    input  wire logic [kwu_pkg::KEY_PINS-1:0] keyWakeupInput,
    input  wire logic                         stopPin,
    // Mode controller side
    output      logic                         stopMode,
    output      logic                         wakeRelease
);
    ////////////////////////////////////////////////////////////////////
    // Bus decode
    localparam int unsigned PAIR_BITS = kwu_pkg::KEY_PINS * kwu_pkg::PAIR_W;

    logic [kwu_pkg::IDX_W-1:0] busIdx;
    logic                      busReq;
    logic                      wrEn;
    logic                      lowByteWr;

    assign busIdx    = wb_adr_i[kwu_pkg::ADDR_W-1:kwu_pkg::IDX_LSB];
    assign busReq    = wb_cyc_i & wb_stb_i;
    assign wrEn      = busReq & wb_we_i & wb_ack_o;
    assign lowByteWr = wrEn & wb_sel_i[0];

    ////////////////////////////////////////////////////////////////////
    // Control registers
    kwu_pkg::ctrl_byte_t ctrlLow_ff;
    kwu_pkg::ctrl_byte_t ctrlHigh_ff;
    kwu_pkg::ctrl_byte_t nxt_ctrlLow;
    kwu_pkg::ctrl_byte_t nxt_ctrlHigh;
    logic                levelMode_ff;
    logic                nxt_levelMode;
    logic                stopCmd_ff;
    logic                nxt_stopCmd;

    always_comb begin
        nxt_ctrlLow   = ctrlLow_ff;
        nxt_ctrlHigh  = ctrlHigh_ff;
        nxt_levelMode = levelMode_ff;
        nxt_stopCmd   = 1'b0;
        if (lowByteWr) begin
            unique case (busIdx)
                kwu_pkg::CTRL_LOW_IDX: begin
                    nxt_ctrlLow = wb_dat_i[kwu_pkg::BYTE_W-1:0];
                end
                kwu_pkg::CTRL_HIGH_IDX: begin
                    nxt_ctrlHigh = wb_dat_i[kwu_pkg::BYTE_W-1:0];
                end
                kwu_pkg::STOP_CTRL_IDX: begin
                    nxt_levelMode = wb_dat_i[kwu_pkg::LEVEL_MODE_BIT];
                    nxt_stopCmd   = wb_dat_i[kwu_pkg::STOP_CMD_BIT];
                end
                default: begin
                    nxt_stopCmd = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrlLow_ff   <= kwu_pkg::CTRL_RESET;
            ctrlHigh_ff  <= kwu_pkg::CTRL_RESET;
            levelMode_ff <= 1'b0;
            stopCmd_ff   <= 1'b0;
        end else begin
            ctrlLow_ff   <= nxt_ctrlLow;
            ctrlHigh_ff  <= nxt_ctrlHigh;
            levelMode_ff <= nxt_levelMode;
            stopCmd_ff   <= nxt_stopCmd;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Pin pair unpacking
    logic [PAIR_BITS-1:0]         ctrlWord;
    logic [kwu_pkg::KEY_PINS-1:0] keyEnable;
    logic [kwu_pkg::KEY_PINS-1:0] keyLevel;

    assign ctrlWord = {ctrlHigh_ff, ctrlLow_ff};

    genvar k;
    generate
        for (k = 0; k < kwu_pkg::KEY_PINS; k++) begin : g_pair
            assign keyEnable[k] = ctrlWord[k*kwu_pkg::PAIR_W + kwu_pkg::ENABLE_OF];
            assign keyLevel[k]  = ctrlWord[k*kwu_pkg::PAIR_W + kwu_pkg::LEVEL_OF];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // Detector and sequencer
    wake_if w ();

    assign w.keyIn     = keyWakeupInput;
    assign w.keyEnable = keyEnable;
    assign w.keyLevel  = keyLevel;
    assign w.stopPin   = stopPin;
    assign w.levelMode = levelMode_ff;
    assign w.stopCmd   = stopCmd_ff;

    release_detect u_detect (
        .w (w.detect)
    );

    stop_sequencer u_seq (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .w       (w.seq)
    );

    // Clockless release path to the mode controller
    assign wakeRelease = w.levelHit;
    assign stopMode    = w.stopActive;

    ////////////////////////////////////////////////////////////////////
    // Sticky status, set wins over clear
    logic skipped_ff;
    logic released_ff;
    logic nxt_skipped;
    logic nxt_released;
    logic statusClr;

    assign statusClr = lowByteWr & (busIdx == kwu_pkg::STATUS_IDX);

    always_comb begin
        nxt_skipped  = skipped_ff;
        nxt_released = released_ff;
        if (statusClr && wb_dat_i[kwu_pkg::ST_SKIP_BIT]) begin
            nxt_skipped = 1'b0;
        end
        if (statusClr && wb_dat_i[kwu_pkg::ST_REL_BIT]) begin
            nxt_released = 1'b0;
        end
        if (w.skipPulse) begin
            nxt_skipped = 1'b1;
        end
        if (w.relPulse) begin
            nxt_released = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            skipped_ff  <= 1'b0;
            released_ff <= 1'b0;
        end else begin
            skipped_ff  <= nxt_skipped;
            released_ff <= nxt_released;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read data and acknowledge
    logic [kwu_pkg::DATA_W-1:0] datO_ff;
    logic [kwu_pkg::DATA_W-1:0] nxt_datO;
    logic                       ackO_ff;
    logic                       nxt_ackO;
    logic [kwu_pkg::DATA_W-1:0] rdMux;

    always_comb begin
        rdMux = '0;
        unique case (busIdx)
            kwu_pkg::CTRL_LOW_IDX: begin
                rdMux[kwu_pkg::BYTE_W-1:0] = ctrlLow_ff;
            end
            kwu_pkg::CTRL_HIGH_IDX: begin
                rdMux[kwu_pkg::BYTE_W-1:0] = ctrlHigh_ff;
            end
            kwu_pkg::STOP_CTRL_IDX: begin
                rdMux[kwu_pkg::LEVEL_MODE_BIT] = levelMode_ff;
            end
            kwu_pkg::STATUS_IDX: begin
                rdMux[kwu_pkg::ST_ACTIVE_BIT] = w.stopActive;
                rdMux[kwu_pkg::ST_HIT_BIT]    = w.levelHit;
                rdMux[kwu_pkg::ST_SKIP_BIT]   = skipped_ff;
                rdMux[kwu_pkg::ST_REL_BIT]    = released_ff;
                rdMux[kwu_pkg::ST_KEYS_LSB +: kwu_pkg::KEY_PINS] = w.keyHit;
            end
            default: begin
                rdMux = '0;
            end
        endcase
    end

    always_comb begin
        nxt_ackO = busReq & ~ackO_ff;
        nxt_datO = datO_ff;
        if (busReq && !ackO_ff) begin
            nxt_datO = rdMux;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ackO_ff <= 1'b0;
            datO_ff <= '0;
        end else begin
            ackO_ff <= nxt_ackO;
            datO_ff <= nxt_datO;
        end
    end

    assign wb_ack_o = ackO_ff;
    assign wb_dat_o = datO_ff;

    ////////////////////////////////////////////////////////////////////
    // Checks
    property p_reset_stop_only;
        @(posedge sys_clk) disable iff (!rst_n)
        (ctrlWord == '0) |-> (wakeRelease == stopPin);
    endproperty
    a_reset_stop_only: assert property (p_reset_stop_only)
        else $error("cleared controls yet a key releases");

    property p_enable_gate;
        @(posedge sys_clk) disable iff (!rst_n)
        (w.keyHit & ~keyEnable) == '0;
    endproperty
    a_enable_gate: assert property (p_enable_gate)
        else $error("disabled key pin reports a hit");

    property p_level_select;
        @(posedge sys_clk) disable iff (!rst_n)
        w.keyHit == (keyEnable & ~(keyWakeupInput ^ keyLevel));
    endproperty
    a_level_select: assert property (p_level_select)
        else $error("key hit does not follow release level");

    property p_low_write;
        @(posedge sys_clk) disable iff (!rst_n)
        lowByteWr && (busIdx == kwu_pkg::CTRL_LOW_IDX)
        |=> (keyEnable[3] == $past(wb_dat_i[6]))
            && (keyLevel[0] == $past(wb_dat_i[1]));
    endproperty
    a_low_write: assert property (p_low_write)
        else $error("low control pairing wrong");

    property p_high_write;
        @(posedge sys_clk) disable iff (!rst_n)
        lowByteWr && (busIdx == kwu_pkg::CTRL_HIGH_IDX)
        |=> (keyEnable[4] == $past(wb_dat_i[0]))
            && (keyLevel[7] == $past(wb_dat_i[7]));
    endproperty
    a_high_write: assert property (p_high_write)
        else $error("high control pairing wrong");

    property p_stop_pin_always;
        @(posedge sys_clk) disable iff (!rst_n)
        stopPin |-> wakeRelease;
    endproperty
    a_stop_pin_always: assert property (p_stop_pin_always)
        else $error("stop pin high without release");

    property p_skip_entry;
        @(posedge sys_clk) disable iff (!rst_n)
        stopCmd_ff && levelMode_ff && wakeRelease && !stopMode
        |=> !stopMode && skipped_ff;
    endproperty
    a_skip_entry: assert property (p_skip_entry)
        else $error("stop entered with release present");

    property p_clockless;
        @(posedge sys_clk) disable iff (!rst_n)
        wakeRelease == (stopPin | (|w.keyHit));
    endproperty
    a_clockless: assert property (p_clockless)
        else $error("release path not direct");

    property p_ack_one;
        @(posedge sys_clk) disable iff (!rst_n)
        busReq && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack_one: assert property (p_ack_one)
        else $error("ack not a single cycle");
endmodule // key_wakeup_stop_release
`default_nettype wire

// ==== tb/key_switch_model.sv ====
// Purpose: Keys and stop switch on the wakeup pins
// Assumes: Each key shorts its pin to ground, pin pulled up when open
// Notes:   Stop switch line is pulled down when open
`timescale 1ns/100ps
`default_nettype none
module key_switch_model (
    // Commands from the bench
    input  wire logic [kwu_pkg::KEY_PINS-1:0] pressed,
    input  wire logic                         stopClosed,
    // Pins seen by the block
    output      logic [kwu_pkg::KEY_PINS-1:0] keyWakeupInput,
    output      logic                         stopPin
);
    // Open key reads high through the pull-up
    assign keyWakeupInput = ~pressed;
    // Stop line stays low unless the stop switch is closed
    assign stopPin = stopClosed;
endmodule // key_switch_model
`default_nettype wire

// ==== tb/tb.sv ====
// Purpose: Self-checking bench for the key wakeup block
// Assumes: One bus access at a time, pins driven through the switch model
// Notes:   Random register and pin values from a fixed seed
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic                         sys_clk;
    logic                         rst_n;
    logic                         wb_cyc_i;
    logic                         wb_stb_i;
    logic                         wb_we_i;
    logic [kwu_pkg::ADDR_W-1:0]   wb_adr_i;
    logic [3:0]                   wb_sel_i;
    logic [kwu_pkg::DATA_W-1:0]   wb_dat_i;
    logic [kwu_pkg::DATA_W-1:0]   wb_dat_o;
    logic                         wb_ack_o;
    logic [kwu_pkg::KEY_PINS-1:0] keyWakeupInput;
    logic                         stopPin;
    logic                         stopMode;
    logic                         wakeRelease;
    logic [kwu_pkg::KEY_PINS-1:0] press;
    logic                         stopClosed;
    logic [31:0]                  rd;
    logic [7:0]                   lo;
    logic [7:0]                   hi;
    int                           seed;
    int                           n_errors;
    int                           tests_run;

    key_switch_model u_keys (
        .pressed        (press),
        .stopClosed     (stopClosed),
        .keyWakeupInput (keyWakeupInput),
        .stopPin        (stopPin)
    );

    key_wakeup_stop_release u_dut (
        .sys_clk        (sys_clk),
        .rst_n          (rst_n),
        .wb_cyc_i       (wb_cyc_i),
        .wb_stb_i       (wb_stb_i),
        .wb_we_i        (wb_we_i),
        .wb_adr_i       (wb_adr_i),
        .wb_sel_i       (wb_sel_i),
        .wb_dat_i       (wb_dat_i),
        .wb_dat_o       (wb_dat_o),
        .wb_ack_o       (wb_ack_o),
        .keyWakeupInput (keyWakeupInput),
        .stopPin        (stopPin),
        .stopMode       (stopMode),
        .wakeRelease    (wakeRelease)
    );

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    task automatic stop_test();
        if (n_errors == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    // Classic single Wishbone cycle, waits for ack under a bound
    task automatic bus(input logic we, input logic [11:0] idx, input logic [7:0] wd,
                       input logic [3:0] sel, output logic [31:0] rdat);
        int n;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= {idx, 2'b00};
        wb_sel_i <= sel;
        wb_dat_i <= {24'h000000, wd};
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (wb_ack_o !== 1'b1) begin
            n_errors++;
            stop_test();
        end else begin
            rdat = wb_dat_o;
            wb_cyc_i <= 1'b0;
            wb_stb_i <= 1'b0;
            wb_we_i  <= 1'b0;
            @(posedge sys_clk);
        end
    endtask

    // Release expected from the two control bytes and the pin levels
    function automatic logic expRel(input logic [7:0] l, input logic [7:0] h,
                                    input logic [7:0] keys, input logic stp);
        logic [15:0] c;
        logic        r;
        c = {h, l};
        r = stp;
        for (int k = 0; k < 8; k++)
            r = r | (c[2*k] & (keys[k] == c[2*k+1]));
        return r;
    endfunction

    // Drive pins at the edge, compare once settled
    task automatic pins(input logic [7:0] p, input logic s);
        press      <= p;
        stopClosed <= s;
        @(negedge sys_clk);
        check({31'h0, wakeRelease}, {31'h0, expRel(lo, hi, ~p, s)});
        @(posedge sys_clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 32'h094C;
        n_errors = 0;
        tests_run = 0;
        rst_n = 1'b0;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = '0;
        wb_sel_i = 4'hF;
        wb_dat_i = '0;
        press = 8'h00;
        stopClosed = 1'b0;
        lo = 8'h00;
        hi = 8'h00;
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        bus(1'b0, kwu_pkg::CTRL_LOW_IDX, 8'h00, 4'hF, rd);
        check(rd, 32'h00000000);
        bus(1'b0, kwu_pkg::CTRL_HIGH_IDX, 8'h00, 4'hF, rd);
        check(rd, 32'h00000000);
        for (int i = 0; i < 4; i++) begin
            rd = $random(seed);
            pins(rd[7:0], 1'b0);
        end
        pins(8'hFF, 1'b1);
        for (int i = 0; i < 4; i++) begin
            rd = $random(seed);
            lo = rd[7:0];
            hi = rd[15:8];
            bus(1'b1, kwu_pkg::CTRL_LOW_IDX, lo, 4'hF, rd);
            bus(1'b1, kwu_pkg::CTRL_HIGH_IDX, hi, 4'hF, rd);
            bus(1'b0, kwu_pkg::CTRL_LOW_IDX, 8'h00, 4'hF, rd);
            check(rd, {24'h000000, lo});
            bus(1'b0, kwu_pkg::CTRL_HIGH_IDX, 8'h00, 4'hF, rd);
            check(rd, {24'h000000, hi});
        end
        bus(1'b1, kwu_pkg::CTRL_LOW_IDX, 8'hA5, 4'hE, rd);
        bus(1'b0, kwu_pkg::CTRL_LOW_IDX, 8'h00, 4'hF, rd);
        check(rd, {24'h000000, lo});
        bus(1'b1, 12'h100, 8'h5A, 4'hF, rd);
        bus(1'b0, 12'h100, 8'h00, 4'hF, rd);
        check(rd, 32'h00000000);
        for (int i = 0; i < 30; i++) begin
            rd = $random(seed);
            lo = rd[7:0];
            hi = rd[15:8];
            bus(1'b1, kwu_pkg::CTRL_LOW_IDX, lo, 4'hF, rd);
            bus(1'b1, kwu_pkg::CTRL_HIGH_IDX, hi, 4'hF, rd);
            for (int j = 0; j < 4; j++) begin
                rd = $random(seed);
                pins(rd[7:0], rd[8]);
            end
        end
        // Corner: all enabled at high level, keys one at a time going high
        lo = 8'hFF;
        hi = 8'hFF;
        bus(1'b1, kwu_pkg::CTRL_LOW_IDX, lo, 4'hF, rd);
        bus(1'b1, kwu_pkg::CTRL_HIGH_IDX, hi, 4'hF, rd);
        pins(8'hFF, 1'b0);
        for (int k = 0; k < 8; k++)
            pins(~(8'h01 << k), 1'b0);
        // Only pin zero enabled, low level releases
        lo = 8'h01;
        hi = 8'h00;
        bus(1'b1, kwu_pkg::CTRL_LOW_IDX, lo, 4'hF, rd);
        bus(1'b1, kwu_pkg::CTRL_HIGH_IDX, hi, 4'hF, rd);
        pins(8'hFE, 1'b0);
        bus(1'b1, kwu_pkg::STOP_CTRL_IDX, 8'h02, 4'hF, rd);
        bus(1'b1, kwu_pkg::STOP_CTRL_IDX, 8'h03, 4'hF, rd);
        @(posedge sys_clk);
        check({31'h0, stopMode}, 32'h00000001);
        pins(8'h01, 1'b0);
        repeat (2) @(posedge sys_clk);
        check({31'h0, stopMode}, 32'h00000000);
        bus(1'b0, kwu_pkg::STATUS_IDX, 8'h00, 4'hF, rd);
        check(rd, 32'h0000010A);
        bus(1'b1, kwu_pkg::STATUS_IDX, 8'h0C, 4'hF, rd);
        bus(1'b1, kwu_pkg::STOP_CTRL_IDX, 8'h03, 4'hF, rd);
        repeat (3) begin
            @(negedge sys_clk);
            check({31'h0, stopMode}, 32'h00000000);
        end
        @(posedge sys_clk);
        bus(1'b0, kwu_pkg::STATUS_IDX, 8'h00, 4'hF, rd);
        check({31'h0, rd[2]}, 32'h00000001);
        check(rd, 32'h00000106);
        bus(1'b0, kwu_pkg::STOP_CTRL_IDX, 8'h00, 4'hF, rd);
        check(rd, 32'h00000002);
        // Edge mode with every key disabled, stop pin rise releases
        lo = 8'h00;
        bus(1'b1, kwu_pkg::CTRL_LOW_IDX, lo, 4'hF, rd);
        pins(8'h00, 1'b0);
        bus(1'b1, kwu_pkg::STOP_CTRL_IDX, 8'h01, 4'hF, rd);
        @(posedge sys_clk);
        check({31'h0, stopMode}, 32'h00000001);
        pins(8'h00, 1'b1);
        @(posedge sys_clk);
        check({31'h0, stopMode}, 32'h00000000);
        pins(8'h00, 1'b0);
        lo = 8'hFF;
        bus(1'b1, kwu_pkg::CTRL_LOW_IDX, lo, 4'hF, rd);
        pins(8'h00, 1'b0);
        // Mid-run reset clears every control and flag
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        lo = 8'h00;
        @(posedge sys_clk);
        pins(8'h00, 1'b0);
        bus(1'b0, kwu_pkg::CTRL_LOW_IDX, 8'h00, 4'hF, rd);
        check(rd, 32'h00000000);
        bus(1'b0, kwu_pkg::STATUS_IDX, 8'h00, 4'hF, rd);
        check(rd, 32'h00000000);
        stop_test();
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        n_errors++;
        stop_test();
    end
endmodule // tb
`default_nettype wire
